// *** mode_map_pkg.sv ***
// Constants, field layout and mode encoding for the mode select and memory map block.
// Assumes one E clock domain and a 32-bit classic Wishbone register port.
`default_nettype none
package mode_map_pkg;
  // Register indices; byte address on the bus is four times the index.
  localparam logic [15:0] PRIO_IDX    = 16'h103C;
  localparam logic [15:0] INIT_IDX    = 16'h103D;
  localparam logic [15:0] CONFIG_IDX  = 16'h103F;
  // Priority and mode register fields.
  localparam int          HP_BOOT     = 7;
  localparam int          HP_SPECIAL_MODE_BIT     = 6;
  localparam int          HP_MDA      = 5;
  localparam int          HP_IRV      = 4;
  localparam logic [3:0]  PSEL_RESET  = 4'h5;
  // Position register and configuration register.
  localparam logic [7:0]  INIT_RESET  = 8'h01;
  localparam logic [7:0]  CFG_RESET   = 8'hFF;
  localparam logic [7:0]  CFG_ONES    = 8'h0A;
  localparam logic [7:0]  CFG_FULL_WR = 8'hF5;
  localparam logic [7:0]  CFG_LC_WR   = 8'h04;
  localparam int          CFG_EEPROM_ON_BIT    = 0;
  // Protected registers may be written once within this many E clocks in normal modes.
  localparam logic [6:0]  WRITE_WINDOW_CYCLES = 7'h40;
  // Address map figures.
  localparam logic [11:0] REG_BLOCK_BYTES = 12'h060;
  localparam logic [7:0]  BOOT_PAGE       = 8'hBF;
  localparam logic [6:0]  EE_FIXED_PAGE   = 7'h7F;
  localparam logic [2:0]  EE_SUB_PAGE     = 3'h7;
  localparam logic [3:0]  HIDDEN_SUB_PAGE = 4'hD;
  localparam logic [9:0]  VECTOR_PAGE     = 10'h3FF;
  typedef enum logic [3:0] {
    MODE_SINGLE   = 4'h1,
    MODE_EXPANDED = 4'h2,
    MODE_BOOT     = 4'h4,
    MODE_TEST     = 4'h8
  } mode_t;
endpackage : mode_map_pkg
`default_nettype wire

// *** mode_map.sv ***
// Operating mode selection, mode register set and internal address decode.
// Assumes clk_i is the E clock, rst_i synchronous, a classic Wishbone master for
// the registers and a CPU address qualified by cpu_valid_i.
//
// Function
// - Decode the full 16-bit, 64-Kbyte address space.
// - After reset RAM sits at 0000-03FF and registers at 1000-105F.
// - In normal modes position register takes one write within 64 E clocks.
// - Registers win over the first 96 bytes when sharing RAM boundary.
// - Low-cost: RAM on any 1K boundary, registers within first 16K.
// - Full: RAM and registers each on any 4K boundary.
// - Full, expanded or test: nonvolatile array at xE00-xFFF when enabled.
// - Single-chip and bootstrap: nonvolatile array fixed at FE00-FFFF.
// - Boot ROM decodes at BF00-BFFF only in bootstrap mode.
// - Mode pins at reset choose single, expanded, bootstrap or test.
// - Boot, special and mode-A bits latch per mode at reset.
// - Single-chip drives no bus; ports become general-purpose pins.
// - Expanded drives address on two ports, data on a third.
// - Bootstrap mode runs the boot ROM loader.
// - Priority field resets to 0101; visibility bit set in special modes.
// - Special test fetches vectors from external addresses.
// - Full, test mode: zD00-zDFF never reach the external bus.
// - Special bit resets to inverse pin B; once cleared it stays clear.
// - Low-cost register field 00..11 places block at 0000..3000.
`timescale 1ns/100ps
`default_nettype none
module mode_map #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input  wire  logic        clk_i,
  input  wire  logic        rst_i,
  input  wire  logic        mode_pin_a_i,
  input  wire  logic        mode_pin_b_i,
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [17:0] wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output logic       [31:0] wb_dat_o,
  output logic              wb_ack_o,
  input  wire  logic        cpu_valid_i,
  input  wire  logic [15:0] cpu_addr_i,
  output logic              ram_sel_o,
  output logic              reg_sel_o,
  output logic              boot_sel_o,
  output logic              eeprom_sel_o,
  output logic              ext_sel_o,
  output logic [3:0]        mode_o,
  output logic              ext_bus_en_o,
  output logic              gpio_mode_o,
  output logic              boot_loader_run_o,
  output logic              internal_read_visible_o,
  output logic              watchdog_disable_o
);

  typedef struct packed {
    logic                  ack;
    logic [7:0]            rdata;
    logic [7:0]            prio;
    logic [7:0]            init;
    logic [7:0]            cfg;
    logic [6:0]            cycles;
    logic                  init_done;
    logic                  irv_done;
    logic                  config_done;
    mode_map_pkg::mode_t   mode;
    logic                  ram_sel;
    logic                  reg_sel;
    logic                  boot_sel;
    logic                  ee_sel;
    logic                  ext_sel;
    logic                  ext_bus;
    logic                  gpio;
    logic                  boot_run;
    logic                  irv_out;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic       wb_req;
  logic       wr_en;
  logic       hit_prio;
  logic       hit_init;
  logic       hit_config;
  logic       special;
  logic       window_open;
  logic [7:0] d;
  logic       ram_hit;
  logic       reg_hit;
  logic       boot_hit;
  logic       ee_hit;
  logic       hidden;
  logic       vector;
  logic [3:0] ee_page;

  always_comb begin
    nxt_st      = st_ff;
    d           = wb_dat_i[7:0];
    wb_req      = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    wr_en       = wb_req & wb_we_i & wb_sel_i[0];
    hit_prio    = (wb_adr_i[17:2] == mode_map_pkg::PRIO_IDX);
    hit_init    = (wb_adr_i[17:2] == mode_map_pkg::INIT_IDX);
    hit_config  = (wb_adr_i[17:2] == mode_map_pkg::CONFIG_IDX);
    special     = st_ff.prio[mode_map_pkg::HP_SPECIAL_MODE_BIT];
    window_open = (st_ff.cycles < mode_map_pkg::WRITE_WINDOW_CYCLES);
    ee_page     = st_ff.cfg[7:4];

    // Bus slave: one wait state, ack for one cycle, unmapped reads give zero.
    nxt_st.ack   = wb_req;
    nxt_st.rdata = 8'h00;
    if (wb_req && !wb_we_i) begin
      if (hit_prio) begin
        nxt_st.rdata = st_ff.prio;
      end else if (hit_init) begin
        nxt_st.rdata = st_ff.init;
      end else if (hit_config) begin
        nxt_st.rdata = st_ff.cfg;
      end
    end

    // The window counter saturates at its limit, so a late write can never wrap back in.
    // Special modes ignore the window entirely; only normal modes consult it.
    if (!window_open) begin
      nxt_st.cycles = st_ff.cycles;
    end else begin
      nxt_st.cycles = st_ff.cycles + 7'h01;
    end

    if (wr_en && hit_prio) begin
      if (special) begin
        nxt_st.prio[mode_map_pkg::HP_BOOT] = d[7];
        nxt_st.prio[mode_map_pkg::HP_SPECIAL_MODE_BIT] = d[6];
        nxt_st.prio[mode_map_pkg::HP_MDA]  = d[5];
      end
      if (special || !st_ff.irv_done) begin
        nxt_st.prio[mode_map_pkg::HP_IRV] = d[4];
        nxt_st.irv_done                   = ~special;
      end
      nxt_st.prio[3:0] = d[3:0];
    end

    if (wr_en && hit_init && (special || (!st_ff.init_done && window_open))) begin
      nxt_st.init      = d;
      nxt_st.init_done = ~special;
    end

    if (wr_en && hit_config && (special || (!st_ff.config_done && window_open))) begin
      if (FULL_VARIANT) begin
        nxt_st.cfg = (d & mode_map_pkg::CFG_FULL_WR) | mode_map_pkg::CFG_ONES;
      end else begin
        // The low-cost variant has no array, so only the watchdog bit is kept.
        nxt_st.cfg = d & mode_map_pkg::CFG_LC_WR;
      end
      nxt_st.config_done = ~special;
    end

    // Mode pins are sampled while reset is held; the last sample before release wins.
    if (rst_i) begin
      nxt_st = '0;
      nxt_st.prio[mode_map_pkg::HP_BOOT] = ~mode_pin_b_i & ~mode_pin_a_i;
      nxt_st.prio[mode_map_pkg::HP_SPECIAL_MODE_BIT] = ~mode_pin_b_i;
      nxt_st.prio[mode_map_pkg::HP_MDA]  = mode_pin_a_i;
      nxt_st.prio[mode_map_pkg::HP_IRV]  = ~mode_pin_b_i;
      nxt_st.prio[3:0]                   = mode_map_pkg::PSEL_RESET;
      nxt_st.init                        = mode_map_pkg::INIT_RESET;
      nxt_st.cfg = FULL_VARIANT ? mode_map_pkg::CFG_RESET : mode_map_pkg::CFG_LC_WR;
    end

    // Mode follows the special and mode-A bits.
    unique case ({nxt_st.prio[mode_map_pkg::HP_SPECIAL_MODE_BIT], nxt_st.prio[mode_map_pkg::HP_MDA]})
      2'b00: nxt_st.mode = mode_map_pkg::MODE_SINGLE;
      2'b01: nxt_st.mode = mode_map_pkg::MODE_EXPANDED;
      2'b10: nxt_st.mode = mode_map_pkg::MODE_BOOT;
      2'b11: nxt_st.mode = mode_map_pkg::MODE_TEST;
    endcase

    nxt_st.ext_bus  = (nxt_st.mode == mode_map_pkg::MODE_EXPANDED) ||
                      (nxt_st.mode == mode_map_pkg::MODE_TEST);
    nxt_st.gpio     = ~nxt_st.ext_bus;
    nxt_st.boot_run = (nxt_st.mode == mode_map_pkg::MODE_BOOT);
    nxt_st.irv_out  = nxt_st.ext_bus & nxt_st.prio[mode_map_pkg::HP_IRV];

    // Address decode over the full 16-bit space, registered for the outputs.
    if (FULL_VARIANT) begin
      ram_hit = (cpu_addr_i[15:12] == st_ff.init[7:4]) && (cpu_addr_i[11:10] == 2'b00);
      reg_hit = (cpu_addr_i[15:12] == st_ff.init[3:0]) &&
                (cpu_addr_i[11:0] < mode_map_pkg::REG_BLOCK_BYTES);
    end else begin
      ram_hit = (cpu_addr_i[15:10] == st_ff.init[7:2]);
      reg_hit = (cpu_addr_i[15:14] == 2'b00) && (cpu_addr_i[13:12] == st_ff.init[1:0]) &&
                (cpu_addr_i[11:0] < mode_map_pkg::REG_BLOCK_BYTES);
    end
    boot_hit = (st_ff.mode == mode_map_pkg::MODE_BOOT) && st_ff.prio[mode_map_pkg::HP_BOOT] &&
               (cpu_addr_i[15:8] == mode_map_pkg::BOOT_PAGE);
    if (st_ff.ext_bus) begin
      ee_hit = (cpu_addr_i[15:12] == ee_page) &&
               (cpu_addr_i[11:9] == mode_map_pkg::EE_SUB_PAGE);
    end else begin
      ee_hit = (cpu_addr_i[15:9] == mode_map_pkg::EE_FIXED_PAGE);
    end
    // The array answers only when it exists and its enable bit is set.
    ee_hit = ee_hit && FULL_VARIANT && st_ff.cfg[mode_map_pkg::CFG_EEPROM_ON_BIT];
    hidden = FULL_VARIANT && (st_ff.mode == mode_map_pkg::MODE_TEST) &&
             (cpu_addr_i[15:12] == ee_page) &&
             (cpu_addr_i[11:8] == mode_map_pkg::HIDDEN_SUB_PAGE);
    vector = (st_ff.mode == mode_map_pkg::MODE_TEST) &&
             (cpu_addr_i[15:6] == mode_map_pkg::VECTOR_PAGE);

    nxt_st.reg_sel  = 1'b0;
    nxt_st.ram_sel  = 1'b0;
    nxt_st.boot_sel = 1'b0;
    nxt_st.ee_sel   = 1'b0;
    nxt_st.ext_sel  = 1'b0;
    if (cpu_valid_i && !rst_i) begin
      if (vector) begin
        nxt_st.ext_sel = 1'b1;
      end else if (reg_hit) begin
        nxt_st.reg_sel = 1'b1;
      end else if (ram_hit) begin
        nxt_st.ram_sel = 1'b1;
      end else if (boot_hit) begin
        nxt_st.boot_sel = 1'b1;
      end else if (ee_hit) begin
        nxt_st.ee_sel = 1'b1;
      end else begin
        nxt_st.ext_sel = st_ff.ext_bus && !hidden;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  assign wb_dat_o                = {24'h000000, st_ff.rdata};
  assign wb_ack_o                = st_ff.ack;
  assign ram_sel_o               = st_ff.ram_sel;
  assign reg_sel_o               = st_ff.reg_sel;
  assign boot_sel_o              = st_ff.boot_sel;
  assign eeprom_sel_o            = st_ff.ee_sel;
  assign ext_sel_o               = st_ff.ext_sel;
  assign mode_o                  = st_ff.mode;
  assign ext_bus_en_o            = st_ff.ext_bus;
  assign gpio_mode_o             = st_ff.gpio;
  assign boot_loader_run_o       = st_ff.boot_run;
  assign internal_read_visible_o = st_ff.irv_out;
  assign watchdog_disable_o      = st_ff.cfg[2];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_init_window_lock: assert property (
    (wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack && hit_init && !special &&
     st_ff.cycles == mode_map_pkg::WRITE_WINDOW_CYCLES) |=> $stable(st_ff.init))
    else $error("position register changed after the write window");
  a_special_mode_bit_sticky: assert property (
    !st_ff.prio[mode_map_pkg::HP_SPECIAL_MODE_BIT] |=> !st_ff.prio[mode_map_pkg::HP_SPECIAL_MODE_BIT])
    else $error("special bit set again after clearing");
  a_pins_latched: assert property (
    $fell(rst_i) |-> (st_ff.prio[mode_map_pkg::HP_SPECIAL_MODE_BIT] == !$past(mode_pin_b_i)) &&
    (st_ff.prio[mode_map_pkg::HP_MDA] == $past(mode_pin_a_i)) &&
    (st_ff.prio[3:0] == mode_map_pkg::PSEL_RESET))
    else $error("mode bits not latched from the pins at reset");
  a_reg_over_ram: assert property (
    reg_sel_o |-> !ram_sel_o && !ext_sel_o)
    else $error("register block and another target selected together");
  a_boot_in_boot: assert property (
    (cpu_valid_i && st_ff.mode == mode_map_pkg::MODE_BOOT && !reg_hit && !ram_hit &&
     st_ff.prio[mode_map_pkg::HP_BOOT] && cpu_addr_i[15:8] == 8'hBF) |=> boot_sel_o)
    else $error("boot ROM not decoded in bootstrap mode");
  a_boot_only_boot: assert property (
    boot_sel_o |-> $past(st_ff.mode) == mode_map_pkg::MODE_BOOT)
    else $error("boot ROM decoded outside bootstrap mode");
  a_vector_external: assert property (
    (cpu_valid_i && st_ff.mode == mode_map_pkg::MODE_TEST && cpu_addr_i[15:6] == 10'h3FF)
    |=> ext_sel_o && !eeprom_sel_o)
    else $error("test mode vector not sent to the external bus");
  a_single_no_bus: assert property (
    (st_ff.mode == mode_map_pkg::MODE_SINGLE) |-> !ext_bus_en_o ##1 !ext_sel_o)
    else $error("external bus used in single-chip mode");
  a_hidden_page: assert property (
    (cpu_valid_i && hidden) |=> !ext_sel_o)
    else $error("hidden test page reached the external bus");
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // Once the window has closed it stays closed until the next reset.
  a_window_closed: assert property (
    (st_ff.cycles == mode_map_pkg::WRITE_WINDOW_CYCLES)
    |=> (st_ff.cycles == mode_map_pkg::WRITE_WINDOW_CYCLES))
    else $error("write window counter left its limit");
  a_one_select: assert property (
    $onehot0({ram_sel_o, reg_sel_o, boot_sel_o, eeprom_sel_o, ext_sel_o}))
    else $error("more than one target selected");
  a_gpio_inverse: assert property (
    gpio_mode_o == !ext_bus_en_o)
    else $error("port mode does not mirror the bus enable");
  a_loader_mode: assert property (
    boot_loader_run_o == (mode_o == mode_map_pkg::MODE_BOOT))
    else $error("loader flag does not follow bootstrap mode");
  a_ram_decode: assert property (
    (cpu_valid_i && ram_hit && !reg_hit && !vector)
    |=> ram_sel_o)
    else $error("RAM address not decoded to RAM");
  a_reg_decode: assert property (
    (cpu_valid_i && reg_hit && !vector)
    |=> reg_sel_o)
    else $error("register address not decoded to the register block");
  a_array_enable: assert property (
    eeprom_sel_o |-> $past(st_ff.cfg[mode_map_pkg::CFG_EEPROM_ON_BIT]))
    else $error("array selected while disabled");
  a_visible_bus: assert property (
    internal_read_visible_o |-> ext_bus_en_o)
    else $error("read visibility without an external bus");
  a_mode_onehot: assert property (
    $onehot(mode_o))
    else $error("mode output not one-hot");
  a_upper_zero: assert property (
    wb_dat_o[31:8] == 24'h000000)
    else $error("unused read data lanes not zero");

  c_window_write: cover property (wr_en && hit_init && !special && window_open);
  c_boot_fetch: cover property (boot_sel_o);
  c_test_external: cover property (ext_sel_o && mode_o == mode_map_pkg::MODE_TEST);
  c_hidden_page: cover property (cpu_valid_i && hidden);
  c_late_write: cover property (wr_en && hit_init && !special && !window_open);

endmodule : mode_map
`default_nettype wire

// *** cpu_model.sv ***
// CPU address source model for the mode select and memory map block.
// Assumes the decoder registers its selects one clock after the address.
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
  input  wire logic        clk_i,
  output var  logic        valid_o,
  output var  logic [15:0] addr_o,
  input  wire logic [4:0]  sel_i
);
  initial begin
    valid_o = 1'b0;
    addr_o  = 16'h0000;
  end
  // One address for one cycle; then the bus carries its inverse so stale values never match.
  task automatic probe(input logic [15:0] a, output logic [4:0] s);
    @(posedge clk_i);
    valid_o <= 1'b1;
    addr_o  <= a;
    @(posedge clk_i);
    valid_o <= 1'b0;
    addr_o  <= ~a;
    #1;
    s = sel_i;
  endtask : probe
endmodule : cpu_model
`default_nettype wire

// *** mode_select_memory_map_bench.sv ***
// Self-checking bench for the mode select and memory map block.
// Assumes the cpu_model file and the design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module mode_select_memory_map_bench;
  int          errors  = 0;
  int          n_tests = 0;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        pin_a   = 1'b1;
  logic        pin_b   = 1'b1;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [17:0] adr     = 18'h00000;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] wdat    = 32'h00000000;
  logic [31:0] rdat;
  logic        ack, cv, ext_en, gpio, bl, internal_read_visible, wd;
  logic [15:0] ca;
  logic [4:0]  sv;
  logic [3:0]  mode;
  logic [7:0]  r;
  logic [4:0]  s;
  logic [1:0]  pins [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
  logic [7:0]  prio [4] = '{8'h05, 8'h25, 8'hD5, 8'h75};

  initial forever #2.5 clk_i = ~clk_i;

  mode_map #(.FULL_VARIANT(1'b1)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .mode_pin_a_i(pin_a), .mode_pin_b_i(pin_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_valid_i(cv),
    .cpu_addr_i(ca), .ram_sel_o(sv[4]), .reg_sel_o(sv[3]), .boot_sel_o(sv[2]),
    .eeprom_sel_o(sv[1]), .ext_sel_o(sv[0]), .mode_o(mode), .ext_bus_en_o(ext_en),
    .gpio_mode_o(gpio), .boot_loader_run_o(bl), .internal_read_visible_o(internal_read_visible),
    .watchdog_disable_o(wd));

  cpu_model cpu_u (.clk_i(clk_i), .valid_o(cv), .addr_o(ca), .sel_i(sv));

  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg

  task automatic chk_sel(input logic [15:0] a, input logic [4:0] e);
    cpu_u.probe(a, s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("[ERR] select at %h expected %b seen %b", a, e, s);
    end
  endtask : chk_sel

  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= 4'h1;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic do_reset(input logic a, input logic b);
    @(posedge clk_i);
    rst_i <= 1'b1;
    pin_a <= a;
    pin_b <= b;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  initial begin
    for (int i = 0; i < 4; i++) begin
      do_reset(pins[i][0], pins[i][1]);
      #1;
      chk_reg("mode", 8'h01 << i, {4'h0, mode});
      chk_reg("ext_en", {7'h00, i[0]}, {7'h00, ext_en});
      chk_reg("gpio", {7'h00, ~i[0]}, {7'h00, gpio});
      chk_reg("loader", {7'h00, i == 2}, {7'h00, bl});
      chk_reg("visible", {7'h00, i == 3}, {7'h00, internal_read_visible});
      chk_reg("watchdog", 8'h01, {7'h00, wd});
      wb(1'b0, mode_map_pkg::PRIO_IDX, 8'h00);
      chk_reg("prio", prio[i], r);
      chk_sel(16'h0000, 5'h10);
      chk_sel(16'h03FF, 5'h10);
      chk_sel(16'h105F, 5'h08);
      chk_sel(16'h1060, i[0] ? 5'h01 : 5'h00);
      chk_sel(16'hBF00, i == 2 ? 5'h04 : (i[0] ? 5'h01 : 5'h00));
      chk_sel(16'hFE00, 5'h02);
      chk_sel(16'hFFFE, i == 3 ? 5'h01 : 5'h02);
      chk_sel(16'hFD00, i == 1 ? 5'h01 : 5'h00);
    end
    wb(1'b1, mode_map_pkg::CONFIG_IDX, 8'h31);
    wb(1'b0, mode_map_pkg::CONFIG_IDX, 8'h00);
    chk_reg("config", 8'h3B, r);
    chk_sel(16'h3E00, 5'h02);
    chk_sel(16'h3D00, 5'h00);
    wb(1'b1, mode_map_pkg::CONFIG_IDX, 8'h30);
    chk_sel(16'h3E00, 5'h01);
    wb(1'b1, mode_map_pkg::PRIO_IDX, 8'h35);
    wb(1'b1, mode_map_pkg::PRIO_IDX, 8'h75);
    wb(1'b0, mode_map_pkg::PRIO_IDX, 8'h00);
    chk_reg("prio_clr", 8'h35, r);
    do_reset(1'b1, 1'b1);
    wb(1'b0, mode_map_pkg::CONFIG_IDX, 8'h00);
    chk_reg("config_rst", 8'hFF, r);
    wb(1'b0, 16'h1040, 8'h00);
    chk_reg("unmapped", 8'h00, r);
    wb(1'b1, mode_map_pkg::INIT_IDX, 8'h11);
    wb(1'b1, mode_map_pkg::INIT_IDX, 8'h22);
    wb(1'b0, mode_map_pkg::INIT_IDX, 8'h00);
    chk_reg("init_once", 8'h11, r);
    chk_sel(16'h1000, 5'h08);
    chk_sel(16'h105F, 5'h08);
    chk_sel(16'h1060, 5'h10);
    chk_sel(16'h13FF, 5'h10);
    chk_sel(16'h0000, 5'h01);
    do_reset(1'b1, 1'b1);
    repeat (64) @(posedge clk_i);
    wb(1'b1, mode_map_pkg::INIT_IDX, 8'h22);
    wb(1'b0, mode_map_pkg::INIT_IDX, 8'h00);
    chk_reg("init_late", 8'h01, r);
    end_of_test();
  end
endmodule : mode_select_memory_map_bench
`default_nettype wire
